// ===== hw/fault_pkg.sv
package fault_pkg;
  localparam logic [11:0] off_payload = 12'h03c;
  localparam logic [11:0] off_target_low = 12'h040;
  localparam logic [11:0] off_target_high = 12'h044;
  localparam logic [11:0] off_irq_status = 12'h050;
  localparam logic [11:0] off_irq_mask = 12'h054;
  localparam logic [11:0] off_cap = 12'h058;
  localparam logic [11:0] off_msg_ctrl = 12'h05c;
  localparam logic [11:0] off_log_base = 12'h100;
  localparam int log_entries = 4;
  localparam int log_idx_w = 2;
  localparam logic [31:0] reset_word = 32'h0000_0000;
  localparam int fault_flag_bit = 127;
  localparam int req_kind_bit = 126;
  localparam int cause_lo = 96;
  localparam int source_lo = 64;
  localparam int st_logged = 0;
  localparam int st_msg_sent = 1;
  localparam int st_w = 2;
endpackage

// ===== hw/log_if.sv
`timescale 1ns/10ps
interface log_if;
  logic fill;
  logic [15:0] source;
  logic [7:0] cause;
  logic kind;
  logic clear;
  logic busy;
  logic [127:0] entry;
  modport owner (input fill, input source, input cause, input kind, input clear,
    output busy, output entry);
  modport user (output fill, output source, output cause, output kind, output clear,
    input busy, input entry);
endinterface

// ===== hw/log_slot.sv
`timescale 1ns/10ps
module log_slot (
  // clock and power-good reset
  input wire logic pclk,
  input wire logic pwrgood_n,
  // slot port
  log_if.owner s
);
  logic [15:0] src_q, src_d;
  logic [7:0] cause_q, cause_d;
  logic kind_q, kind_d;
  logic flag_q, flag_d;
  logic stage_q, stage_d;

  always_comb begin
    src_d = src_q;
    cause_d = cause_q;
    kind_d = kind_q;
    stage_d = 1'b0;
    flag_d = flag_q;
    if (s.fill && !flag_q && !stage_q) begin
      src_d = s.source;
      cause_d = s.cause;
      kind_d = s.kind;
      stage_d = 1'b1;
    end
    // flag rises a cycle after details land
    if (stage_q) flag_d = 1'b1;
    else if (s.clear) flag_d = 1'b0;
  end

  // sticky: only power-good reset reaches these
  always_ff @(posedge pclk or negedge pwrgood_n) begin
    if (!pwrgood_n) begin
      src_q <= 16'h0000;
      cause_q <= 8'h00;
      kind_q <= 1'b0;
      flag_q <= 1'b0;
      stage_q <= 1'b0;
    end else begin
      src_q <= src_d;
      cause_q <= cause_d;
      kind_q <= kind_d;
      flag_q <= flag_d;
      stage_q <= stage_d;
    end
  end

  assign s.busy = flag_q | stage_q;
  assign s.entry = {flag_q, kind_q, 22'h0, cause_q, 16'h0000, src_q, 64'h0};

  flag_after_detail_a: assert property (@(posedge pclk) disable iff (!pwrgood_n)
    $rose(flag_q) |-> $past(stage_q)) else $error("flag set without detail stage");
  one_clears_flag_a: assert property (@(posedge pclk) disable iff (!pwrgood_n)
    flag_q && s.clear && !stage_q |=> !flag_q) else $error("flag not cleared");
  kind_kept_a: assert property (@(posedge pclk) disable iff (!pwrgood_n)
    flag_q && !s.clear |=> kind_q == $past(kind_q)) else $error("kind changed");
endmodule

// ===== hw/fault_event_msg_and_record.sv
`timescale 1ns/10ps
module fault_event_msg_and_record #(
  parameter bit wide_data = 1'b1,
  parameter bit ext_irq_mode = 1'b1
) (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrgood_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fault report from translation logic
  input wire logic fault_valid,
  input wire logic [15:0] fault_source,
  input wire logic [7:0] fault_cause,
  input wire logic fault_is_read,
  output logic fault_ready,
  // message write toward fabric
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [63:0] msg_addr,
  output logic [31:0] msg_data,
  // interrupt
  output logic irq
);
  logic [31:0] payload_q, payload_d;
  logic [29:0] target_low_q, target_low_d;
  logic [31:0] target_high_q, target_high_d;
  logic [fault_pkg::st_w-1:0] status_q, status_d, mask_q, mask_d;
  logic irq_pending_q, irq_pending_d;
  logic msg_en_q, msg_en_d;
  logic msg_valid_q, msg_valid_d;
  logic [63:0] msg_addr_q, msg_addr_d;
  logic [31:0] msg_data_q, msg_data_d;
  logic [31:0] rdata_q, rdata_d;
  logic ppf_q, ppf_d;

  logic acc, wr, rd, hit;
  logic wait_q;
  logic [fault_pkg::log_idx_w-1:0] pick;
  logic merge, free_found, logged;
  logic [fault_pkg::log_entries-1:0] busy, fill, clr, same;
  logic [127:0] entries [fault_pkg::log_entries];
  logic [11:0] log_off;

  log_if slot_if [fault_pkg::log_entries] ();

  genvar g;
  generate
    for (g = 0; g < fault_pkg::log_entries; g++) begin : slot
      assign slot_if[g].fill = fill[g];
      assign slot_if[g].source = fault_source;
      assign slot_if[g].cause = fault_cause;
      assign slot_if[g].kind = fault_is_read;
      assign slot_if[g].clear = clr[g];
      assign busy[g] = slot_if[g].busy;
      assign entries[g] = slot_if[g].entry;
      assign same[g] = busy[g] && entries[g][fault_pkg::source_lo +: 16] == fault_source;
      log_slot u_slot (
        .pclk(pclk),
        .pwrgood_n(pwrgood_n),
        .s(slot_if[g])
      );
    end
  endgenerate

  assign acc = psel && penable;
  // writes land only at the edge where pready is seen high
  assign wr = acc && pwrite && wait_q;
  assign rd = acc && !pwrite;
  assign log_off = paddr - fault_pkg::off_log_base;

  // slot choice: merge first, else lowest free entry
  always_comb begin
    merge = |same;
    free_found = 1'b0;
    pick = '0;
    for (int i = fault_pkg::log_entries - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        free_found = 1'b1;
        pick = i[fault_pkg::log_idx_w-1:0];
      end
    end
    fill = '0;
    if (fault_valid && !merge && free_found) fill[pick] = 1'b1;
    logged = fault_valid && !merge && free_found;
  end
  // a full log drops the fault; merged faults are absorbed
  assign fault_ready = 1'b1;

  always_comb begin
    clr = '0;
    for (int i = 0; i < fault_pkg::log_entries; i++) begin
      if (wr && log_off[11:4] == 8'(i) && log_off[3:2] == 2'h3 && pwdata[31])
        clr[i] = 1'b1;
    end
  end

  always_comb begin
    payload_d = payload_q;
    target_low_d = target_low_q;
    target_high_d = target_high_q;
    mask_d = mask_q;
    msg_en_d = msg_en_q;
    status_d = status_q;
    ppf_d = ppf_q;
    hit = 1'b1;
    rdata_d = fault_pkg::reset_word;
    if (wr) begin
      unique case (paddr)
        fault_pkg::off_payload: begin
          payload_d[15:0] = pwdata[15:0];
          if (wide_data) payload_d[31:16] = pwdata[31:16];
        end
        fault_pkg::off_target_low: target_low_d = pwdata[31:2];
        fault_pkg::off_target_high: begin
          if (ext_irq_mode) target_high_d = pwdata;
        end
        fault_pkg::off_irq_mask: mask_d = pwdata[fault_pkg::st_w-1:0];
        fault_pkg::off_msg_ctrl: msg_en_d = pwdata[0];
        default: hit = paddr >= fault_pkg::off_log_base
          && log_off[11:4] < 8'(fault_pkg::log_entries);
      endcase
    end
    if (rd) begin
      unique case (paddr)
        fault_pkg::off_payload: rdata_d = payload_q;
        fault_pkg::off_target_low: rdata_d = {target_low_q, 2'b00};
        fault_pkg::off_target_high: rdata_d = target_high_q;
        fault_pkg::off_irq_status: begin
          rdata_d = {irq_pending_q, ppf_q, 28'h0, status_q};
          if (wait_q) status_d = '0;
        end
        fault_pkg::off_irq_mask: rdata_d = {30'h0, mask_q};
        fault_pkg::off_cap: rdata_d = {8'h0, fault_pkg::off_log_base, 12'(fault_pkg::log_entries)};
        fault_pkg::off_msg_ctrl: rdata_d = {31'h0, msg_en_q};
        default: begin
          hit = paddr >= fault_pkg::off_log_base
            && log_off[11:4] < 8'(fault_pkg::log_entries);
          if (hit) rdata_d = entries[log_off[5:4]][log_off[3:2]*32 +: 32];
        end
      endcase
    end
    // set wins over a read clear
    if (logged) status_d[fault_pkg::st_logged] = 1'b1;
    if (msg_valid_q && msg_ready) status_d[fault_pkg::st_msg_sent] = 1'b1;
    ppf_d = |busy;
  end

  // interrupt pending and message issue
  always_comb begin
    irq_pending_d = irq_pending_q;
    msg_valid_d = msg_valid_q;
    msg_addr_d = msg_addr_q;
    msg_data_d = msg_data_q;
    if (logged) irq_pending_d = 1'b1;
    if (msg_valid_q && msg_ready) begin
      msg_valid_d = 1'b0;
      irq_pending_d = logged;
    end else if (!msg_valid_q && irq_pending_q && msg_en_q) begin
      msg_valid_d = 1'b1;
      msg_addr_d = {target_high_q, target_low_q, 2'b00};
      msg_data_d = payload_q;
    end
    if (!ppf_q && !logged && !msg_valid_q) irq_pending_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      payload_q <= fault_pkg::reset_word;
      target_low_q <= 30'h0;
      target_high_q <= fault_pkg::reset_word;
      status_q <= '0;
      mask_q <= '0;
      msg_en_q <= 1'b0;
      rdata_q <= fault_pkg::reset_word;
      ppf_q <= 1'b0;
      irq_pending_q <= 1'b0;
      msg_valid_q <= 1'b0;
      msg_addr_q <= 64'h0;
      msg_data_q <= fault_pkg::reset_word;
    end else begin
      payload_q <= payload_d;
      target_low_q <= target_low_d;
      target_high_q <= target_high_d;
      status_q <= status_d;
      mask_q <= mask_d;
      msg_en_q <= msg_en_d;
      rdata_q <= rdata_d;
      ppf_q <= ppf_d;
      irq_pending_q <= irq_pending_d;
      msg_valid_q <= msg_valid_d;
      msg_addr_q <= msg_addr_d;
      msg_data_q <= msg_data_d;
    end
  end

  // read data comes one cycle after the access edge, so pready waits one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wait_q <= 1'b0;
    else wait_q <= acc && !wait_q;
  end
  assign pready = wait_q;
  assign pslverr = 1'b0;
  assign prdata = rdata_q;
  assign msg_valid = msg_valid_q;
  assign msg_addr = msg_addr_q;
  assign msg_data = msg_data_q;
  assign irq = |(status_q & mask_q);

  low_bits_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == fault_pkg::off_target_low |-> prdata[1:0] == 2'b00)
    else $error("target low bits not zero");
  payload_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == fault_pkg::off_payload
    |=> payload_q[15:0] == $past(pwdata[15:0]))
    else $error("payload not written");
  upper_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wide_data |-> payload_q[31:16] == 16'h0000) else $error("upper half set");
  high_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ext_irq_mode |-> target_high_q == 32'h0) else $error("upper target set");
  log_pends_a: assert property (@(posedge pclk) disable iff (!presetn)
    logged |=> irq_pending_q) else $error("pending not raised");
  msg_form_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(msg_valid_q) |-> msg_addr_q == {$past(target_high_q), $past(target_low_q), 2'b00}
    && msg_data_q == $past(payload_q)) else $error("message malformed");
  msg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid_q && !msg_ready |=> msg_valid_q && $stable(msg_addr_q))
    else $error("message dropped");
  merge_no_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_valid && merge |-> fill == '0) else $error("merge filled new slot");
endmodule

// ===== test/msg_sink.sv
`timescale 1ns/10ps
module msg_sink (
  // clock
  input wire logic pclk,
  // message write from the block
  input wire logic msg_valid,
  input wire logic [63:0] msg_addr,
  input wire logic [31:0] msg_data,
  output logic msg_ready,
  // bench control and observation
  input wire logic [7:0] stall,
  output logic [63:0] seen_addr,
  output logic [31:0] seen_data,
  output logic [7:0] got
);
  logic [7:0] cnt;
  initial begin
    msg_ready = 1'b0;
    got = 8'h00;
    cnt = 8'h00;
  end
  // ready only while a write is offered, so stalls look like a busy fabric
  always @(posedge pclk) begin
    if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
      got <= got + 8'h01;
      seen_addr <= msg_addr;
      seen_data <= msg_data;
      msg_ready <= 1'b0;
      cnt <= 8'h00;
    end else if (msg_valid === 1'b1) begin
      if (cnt >= stall) begin
        msg_ready <= 1'b1;
      end
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ===== test/fault_event_msg_and_record_tb_top.sv
`timescale 1ns/10ps
module fault_event_msg_and_record_tb_top;
  logic pclk = 0, presetn = 0, pwrgood_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seen_data, msg_data;
  logic pready, pslverr, fault_valid = 0, fault_is_read = 0, fault_ready;
  logic [15:0] fault_source = 16'h0;
  logic [7:0] fault_cause = 8'h00, stall = 8'h03, got;
  logic msg_valid, msg_ready, irq;
  logic [63:0] msg_addr, seen_addr;
  logic [11:0] lb;
  int n_mismatch = 0, compares = 0, k;

  fault_event_msg_and_record fault_event_msg_and_record_i (.pclk(pclk), .presetn(presetn),
    .pwrgood_n(pwrgood_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_valid(fault_valid), .fault_source(fault_source), .fault_cause(fault_cause),
    .fault_is_read(fault_is_read), .fault_ready(fault_ready), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_addr(msg_addr), .msg_data(msg_data), .irq(irq));
  msg_sink msg_sink_i (.pclk(pclk), .msg_valid(msg_valid), .msg_addr(msg_addr),
    .msg_data(msg_data), .msg_ready(msg_ready), .stall(stall), .seen_addr(seen_addr),
    .seen_data(seen_data), .got(got));

  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // idle cycle first so psel is never driven twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      wrap_up();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask

  task automatic fault(input logic [15:0] s, input logic [7:0] c, input logic r);
    @(posedge pclk);
    fault_valid <= 1'b1;
    fault_source <= s;
    fault_cause <= c;
    fault_is_read <= r;
    @(posedge pclk);
    fault_valid <= 1'b0;
    fault_source <= ~s;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    lb = fault_pkg::off_log_base;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    pwrgood_n <= 1'b1;
    rchk(fault_pkg::off_payload, 32'h0, "payload reset");
    rchk(fault_pkg::off_target_low, 32'h0, "target low reset");
    rchk(fault_pkg::off_target_high, 32'h0, "target high reset");
    xfer(1'b1, fault_pkg::off_payload, 32'hdead_beef);
    rchk(fault_pkg::off_payload, 32'hdead_beef, "payload");
    xfer(1'b1, fault_pkg::off_target_low, 32'hffff_ffff);
    rchk(fault_pkg::off_target_low, 32'hffff_fffc, "target low");
    xfer(1'b1, fault_pkg::off_target_high, 32'h0000_00a5);
    rchk(fault_pkg::off_target_high, 32'h0000_00a5, "target high");
    rchk(fault_pkg::off_cap, 32'h0010_0004, "capability");
    rchk(12'h0f0, 32'h0, "unmapped");
    $display("test registers done");
    xfer(1'b1, fault_pkg::off_irq_mask, 32'h1);
    xfer(1'b1, fault_pkg::off_msg_ctrl, 32'h1);
    fault(16'h1234, 8'h05, 1'b1);
    for (k = 0; k < 50 && got == 8'h00; k++) @(posedge pclk);
    if (k >= 50) begin
      n_mismatch++;
      wrap_up();
    end
    chk(seen_addr[63:32], 32'h0000_00a5, "msg addr high");
    chk(seen_addr[31:0], 32'hffff_fffc, "msg addr low");
    chk(seen_data, 32'hdead_beef, "msg data");
    chk({31'h0, irq}, 32'h1, "irq raised");
    rchk(lb + 12'h00c, 32'hc000_0005, "entry0 flag kind cause");
    rchk(lb + 12'h008, 32'h0000_1234, "entry0 source");
    stall <= 8'h00;
    fault(16'h1234, 8'h07, 1'b0);
    rchk(lb + 12'h01c, 32'h0, "merged same source");
    fault(16'h0042, 8'h02, 1'b0);
    rchk(lb + 12'h01c, 32'h8000_0002, "entry1 write kind");
    xfer(1'b0, fault_pkg::off_irq_status, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "status logged");
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "irq after status read");
    $display("test faults done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(lb + 12'h00c, 32'hc000_0005, "sticky over reset");
    rchk(fault_pkg::off_payload, 32'h0, "payload after reset");
    xfer(1'b1, lb + 12'h00c, 32'h0);
    rchk(lb + 12'h00c, 32'hc000_0005, "zero write ignored");
    xfer(1'b1, lb + 12'h00c, 32'h8000_0000);
    rchk(lb + 12'h00c, 32'h4000_0005, "one write clears");
    $display("test clear done");
    wrap_up();
  end
endmodule
